// File: core/cfs_loader.sv
`timescale 1ns/100ps
module cfs_loader #(
    parameter int POR_CYCLES = 16,
    parameter int PULSE_CYCLES = 8
) (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_link_clk,
    input wire logic i_status,
    output logic o_status_oe_n,
    input wire logic i_conf_done,
    output logic o_config_clock_out,
    output logic [7:0] o_data,
    output cfs_pkg::cfs_flash_s o_flash,
    input wire logic [15:0] i_flash_rdata,
    input wire cfs_pkg::cfs_prog_s i_prog,
    output logic o_prog_ready,
    output logic o_idle
);

    // ****************************************
    // Core domain state
    // ****************************************
    typedef struct packed {
        cfs_pkg::cfs_state_e st;
        logic [15:0] cnt;
        logic [15:0] words;
        logic [15:0] word;
        logic [1:0] pend;
        logic [7:0] txb;
        logic req;
        logic [2:0] wc;
        logic run;
        logic all_sent;
        logic fin;
        logic stat_oe_n;
        logic [2:0] st_s;
        logic stat;
        logic [2:0] cd_s;
        logic cd;
        logic [1:0] ack_s;
        logic [2:0] ok_s;
        logic [2:0] err_s;
        logic prog_ready;
        logic idle;
        cfs_pkg::cfs_flash_s fl;
    } cfs_core_s;

    typedef struct packed {
        cfs_pkg::cfs_lstate_e lst;
        logic ph;
        logic [7:0] sh;
        logic [3:0] nb;
        logic clk;
        logic [7:0] data;
        logic ack;
        logic [1:0] req_s;
        logic [1:0] run_s;
        logic [1:0] sent_s;
        logic [1:0] fin_s;
        logic [5:0] wc_s;
        logic [2:0] wc;
        logic [2:0] cd_s;
        logic cd;
        logic [6:0] cnt;
        logic ok_t;
        logic err_t;
    } cfs_link_s;

    localparam cfs_pkg::cfs_flash_s FL_REL = '{drive_n: 1'b1, ce_n: 1'b1, oe_n: 1'b1,
        we_n: 1'b1, addr: '0, wdata: '0};

    cfs_core_s c;
    cfs_core_s next_c;
    cfs_link_s l;
    cfs_link_s next_l;
    logic [1:0] lrst_q;
    logic lrst;
    logic ok_ev;
    logic err_ev;

    assign ok_ev = c.ok_s[1] ^ c.ok_s[2];
    assign err_ev = c.err_s[1] ^ c.err_s[2];

    // ****************************************
    // Core domain: flash reads and sequencing
    // ****************************************
    always_comb begin
        next_c = c;
        next_c.st_s = {c.st_s[1:0], i_status};
        if (c.st_s[1] == c.st_s[2]) begin
            next_c.stat = c.st_s[1];
        end
        next_c.cd_s = {c.cd_s[1:0], i_conf_done};
        if (c.cd_s[1] == c.cd_s[2]) begin
            next_c.cd = c.cd_s[1];
        end
        next_c.ack_s = {c.ack_s[0], l.ack};
        next_c.ok_s = {c.ok_s[1:0], l.ok_t};
        next_c.err_s = {c.err_s[1:0], l.err_t};
        case (c.st)
            cfs_pkg::S_POR: begin
                if (c.cnt == 16'h0000) begin
                    next_c.st = cfs_pkg::S_OPT;
                    next_c.cnt = 16'(cfs_pkg::ACC_CYC);
                    next_c.fl = '{drive_n: 1'b0, ce_n: 1'b0, oe_n: 1'b0, we_n: 1'b1,
                        addr: cfs_pkg::OPT_WIDTH_ADDR, wdata: '0};
                end else begin
                    next_c.cnt = c.cnt - 16'h0001;
                end
            end
            cfs_pkg::S_OPT: begin
                if (c.cnt != 16'h0001) begin
                    next_c.cnt = c.cnt - 16'h0001;
                end else if (c.fl.addr == cfs_pkg::OPT_WIDTH_ADDR) begin
                    next_c.wc = i_flash_rdata[2:0];
                    next_c.fl.addr = cfs_pkg::OPT_LEN_ADDR;
                    next_c.cnt = 16'(cfs_pkg::ACC_CYC);
                end else begin
                    next_c.words = i_flash_rdata;
                    next_c.fl = FL_REL;
                    next_c.fl.addr = cfs_pkg::DATA_BASE;
                    next_c.stat_oe_n = 1'b1;
                    next_c.st = cfs_pkg::S_WAIT;
                end
            end
            cfs_pkg::S_WAIT: begin
                if (c.stat && !c.cd) begin
                    next_c.st = cfs_pkg::S_CFG;
                    next_c.run = 1'b1;
                    next_c.all_sent = 1'b0;
                    next_c.pend = 2'h0;
                    next_c.fl.drive_n = 1'b0;
                    next_c.fl.ce_n = 1'b0;
                end
            end
            cfs_pkg::S_CFG: begin
                if (!c.stat) begin
                    next_c.st = cfs_pkg::S_HOLD;
                    next_c.run = 1'b0;
                    next_c.fl = FL_REL;
                end else if (c.pend == 2'h0 && c.words != 16'h0000) begin
                    if (c.fl.oe_n) begin
                        next_c.fl.oe_n = 1'b0;
                        next_c.cnt = 16'(cfs_pkg::ACC_CYC);
                    end else if (c.cnt != 16'h0001) begin
                        next_c.cnt = c.cnt - 16'h0001;
                    end else begin
                        next_c.word = i_flash_rdata;
                        next_c.pend = 2'h2;
                        next_c.fl.addr = c.fl.addr + 21'h0_0001;
                        next_c.words = c.words - 16'h0001;
                        next_c.fl.oe_n = 1'b1;
                    end
                end else if (c.req == c.ack_s[1]) begin
                    if (c.pend != 2'h0) begin
                        next_c.txb = (c.pend == 2'h2) ? c.word[7:0] : c.word[15:8];
                        next_c.req = ~c.req;
                        next_c.pend = c.pend - 2'h1;
                    end else begin
                        next_c.all_sent = 1'b1;
                        next_c.fl = FL_REL;
                        next_c.st = cfs_pkg::S_CHK;
                    end
                end
            end
            cfs_pkg::S_CHK: begin
                if (ok_ev) begin
                    next_c.fin = 1'b1;
                    next_c.run = 1'b0;
                    next_c.st = cfs_pkg::S_IDLE;
                end else if (err_ev) begin
                    next_c.run = 1'b0;
                    next_c.stat_oe_n = 1'b0;
                    next_c.cnt = 16'(PULSE_CYCLES);
                    next_c.st = cfs_pkg::S_PULSE;
                end else if (!c.stat) begin
                    next_c.run = 1'b0;
                    next_c.st = cfs_pkg::S_HOLD;
                end
            end
            cfs_pkg::S_IDLE: begin
                if (!c.stat) begin
                    next_c.fin = 1'b0;
                    next_c.st = cfs_pkg::S_HOLD;
                end else if (i_prog.valid) begin
                    next_c.fl = '{drive_n: 1'b0, ce_n: 1'b0, oe_n: 1'b1, we_n: 1'b0,
                        addr: i_prog.addr, wdata: i_prog.wdata};
                    next_c.cnt = 16'(cfs_pkg::ACC_CYC);
                    next_c.st = cfs_pkg::S_PROG;
                end
            end
            cfs_pkg::S_PROG: begin
                if (c.cnt != 16'h0001) begin
                    next_c.cnt = c.cnt - 16'h0001;
                end else begin
                    next_c.fl = FL_REL;
                    next_c.st = cfs_pkg::S_IDLE;
                end
            end
            cfs_pkg::S_PULSE: begin
                if (c.cnt != 16'h0001) begin
                    next_c.cnt = c.cnt - 16'h0001;
                end else begin
                    next_c.stat_oe_n = 1'b1;
                    next_c.st = cfs_pkg::S_HOLD;
                end
            end
            default: begin
                next_c.fl = FL_REL;
                next_c.run = 1'b0;
                next_c.fin = 1'b0;
                if (c.stat) begin
                    next_c.st = cfs_pkg::S_OPT;
                    next_c.stat_oe_n = 1'b0;
                    next_c.cnt = 16'(cfs_pkg::ACC_CYC);
                    next_c.fl = '{drive_n: 1'b0, ce_n: 1'b0, oe_n: 1'b0, we_n: 1'b1,
                        addr: cfs_pkg::OPT_WIDTH_ADDR, wdata: '0};
                end
            end
        endcase
        next_c.prog_ready = (next_c.st == cfs_pkg::S_IDLE);
        next_c.idle = (next_c.st == cfs_pkg::S_IDLE);
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            c <= '0;
            c.st <= cfs_pkg::S_POR;
            c.cnt <= 16'(POR_CYCLES);
            c.stat_oe_n <= 1'b0;
            c.fl <= FL_REL;
            c.st_s <= 3'h7;
            c.stat <= 1'b1;
        end else begin
            c <= next_c;
        end
    end

    // ****************************************
    // Link domain: configuration clock and data
    // ****************************************
    always_ff @(posedge i_link_clk) begin
        lrst_q <= {lrst_q[0], i_rst};
    end
    assign lrst = lrst_q[1];

    always_comb begin
        next_l = l;
        next_l.req_s = {l.req_s[0], c.req};
        next_l.run_s = {l.run_s[0], c.run};
        next_l.sent_s = {l.sent_s[0], c.all_sent};
        next_l.fin_s = {l.fin_s[0], c.fin};
        next_l.wc_s = {l.wc_s[2:0], c.wc};
        next_l.cd_s = {l.cd_s[1:0], i_conf_done};
        if (l.cd_s[1] == l.cd_s[2]) begin
            next_l.cd = l.cd_s[1];
        end
        if (!l.run_s[1]) begin
            next_l.lst = cfs_pkg::L_OFF;
            next_l.nb = 4'h0;
            next_l.ph = 1'b0;
            next_l.clk = 1'b0;
            next_l.data = l.fin_s[1] ? cfs_pkg::DATA_DONE : cfs_pkg::DATA_ZERO;
            next_l.wc = l.wc_s[5:3];
            if (l.req_s[1] != l.ack) begin
                next_l.ack = ~l.ack;
            end
        end else begin
            case (l.lst)
                cfs_pkg::L_OFF: begin
                    next_l.lst = cfs_pkg::L_RUN;
                end
                cfs_pkg::L_RUN: begin
                    if (l.ph) begin
                        next_l.clk = 1'b1;
                        next_l.sh = l.sh >> cfs_pkg::cfs_step(l.wc);
                        next_l.nb = l.nb - cfs_pkg::cfs_step(l.wc);
                        next_l.ph = 1'b0;
                    end else begin
                        next_l.clk = 1'b0;
                        if (l.nb != 4'h0) begin
                            next_l.data = l.sh & cfs_pkg::cfs_mask(l.wc);
                            next_l.ph = 1'b1;
                        end else if (l.req_s[1] != l.ack) begin
                            next_l.sh = c.txb;
                            next_l.nb = 4'h8;
                            next_l.ack = ~l.ack;
                        end else if (l.sent_s[1]) begin
                            next_l.lst = cfs_pkg::L_CHK;
                            next_l.cnt = 7'h00;
                        end
                    end
                end
                cfs_pkg::L_CHK: begin
                    if (l.ph) begin
                        next_l.clk = 1'b1;
                        next_l.cnt = l.cnt + 7'h01;
                        next_l.ph = 1'b0;
                    end else begin
                        next_l.clk = 1'b0;
                        next_l.ph = 1'b1;
                        if (l.cd) begin
                            next_l.ok_t = ~l.ok_t;
                            next_l.lst = cfs_pkg::L_DONE;
                        end else if (l.cnt == cfs_pkg::DONE_TIMEOUT) begin
                            next_l.err_t = ~l.err_t;
                            next_l.lst = cfs_pkg::L_DONE;
                        end
                    end
                end
                default: begin
                    next_l.clk = 1'b0;
                    next_l.ph = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge i_link_clk) begin
        if (lrst) begin
            l <= '0;
        end else begin
            l <= next_l;
        end
    end

    assign o_status_oe_n = c.stat_oe_n;
    assign o_flash = c.fl;
    assign o_prog_ready = c.prog_ready;
    assign o_idle = c.idle;
    assign o_config_clock_out = l.clk;
    assign o_data = l.data;

    // ****************************************
    // Checks
    // ****************************************
    serial_bits_low_a: assert property (@(posedge i_link_clk) disable iff (lrst)
        (l.lst == cfs_pkg::L_RUN && l.wc == cfs_pkg::W1) |-> (l.data[7:1] == 7'h00))
        else $error("serial mode drives upper data lines");
    unused_lines_low_a: assert property (@(posedge i_link_clk) disable iff (lrst)
        (l.lst != cfs_pkg::L_OFF) |-> ((l.data & ~cfs_pkg::cfs_mask(l.wc)) == 8'h00))
        else $error("data line above width is high");
    data_stable_a: assert property (@(posedge i_link_clk) disable iff (lrst)
        $rose(l.clk) |-> $stable(l.data))
        else $error("data changed at rising clock");
    pause_clock_a: assert property (@(posedge i_link_clk) disable iff (lrst)
        (l.run_s[1] && l.lst == cfs_pkg::L_RUN && !l.ph && l.nb == 4'h0 &&
        l.req_s[1] == l.ack) |=> !l.clk)
        else $error("clock ran without data");
    width_hold_a: assert property (@(posedge i_link_clk) disable iff (lrst)
        (l.lst != cfs_pkg::L_OFF && l.run_s[1]) |=> $stable(l.wc))
        else $error("width changed during configuration");
    done_timeout_a: assert property (@(posedge i_link_clk) disable iff (lrst)
        (l.run_s[1] && l.lst == cfs_pkg::L_CHK && !l.ph && !l.cd &&
        l.cnt == cfs_pkg::DONE_TIMEOUT) |=> (l.err_t != $past(l.err_t)))
        else $error("missing done timeout");
    done_levels_a: assert property (@(posedge i_link_clk) disable iff (lrst)
        (l.fin_s[1] && !l.run_s[1]) |=> (l.data == 8'hFF && !l.clk))
        else $error("wrong levels after completion");
    idle_release_a: assert property (@(posedge i_clk) disable iff (i_rst)
        (c.st == cfs_pkg::S_IDLE) |-> (c.fl.drive_n && c.fl.ce_n && c.fl.we_n))
        else $error("flash bus held in idle");
    own_bus_a: assert property (@(posedge i_clk) disable iff (i_rst)
        (c.st == cfs_pkg::S_OPT || c.st == cfs_pkg::S_CFG || c.st == cfs_pkg::S_PROG)
        |-> !c.fl.drive_n)
        else $error("flash bus not owned during access");
    halt_release_a: assert property (@(posedge i_clk) disable iff (i_rst)
        (c.st == cfs_pkg::S_CFG && !c.stat) |=> (c.st == cfs_pkg::S_HOLD &&
        c.fl.drive_n && !c.run))
        else $error("no halt on status low");
    error_pulse_a: assert property (@(posedge i_clk) disable iff (i_rst)
        (c.st == cfs_pkg::S_CHK && err_ev && !ok_ev) |=> (c.st == cfs_pkg::S_PULSE &&
        !c.stat_oe_n))
        else $error("no status pulse on done error");

endmodule // cfs_loader

// File: shared/cfs_pkg.sv
// Behaviour
// - Serial width: one bit per clock on data bit 0, bits 7..1 low.
// - Concurrent width: n bits per clock on low n lines, n is 2, 4 or 8.
// - Any detected error halts and restarts the whole chain via status line.
// - Controller is primary flash master; both masters never drive together.
// - Controller owns flash for config reads, programming writes, option reads.
// - After configuration or programming, release flash bus and go idle.
// - Data lines above selected width n are driven low.
// - Stop configuration clock while next data is not yet available.
// - Done not released within 64 clocks after last bit: pulse status low.
// - After completion, configuration clock low and all data lines high.
package cfs_pkg;

    // ****************************************
    // Widths and timing
    // ****************************************
    localparam int FA_W = 21;
    localparam int CLK_NS = 4;
    localparam int ACCESS_NS = 90;
    localparam int ACC_CYC = (ACCESS_NS + CLK_NS - 1) / CLK_NS;
    localparam logic [6:0] DONE_TIMEOUT = 7'h40;
    localparam logic [FA_W-1:0] OPT_WIDTH_ADDR = 21'h0_0000;
    localparam logic [FA_W-1:0] OPT_LEN_ADDR = 21'h0_0001;
    localparam logic [FA_W-1:0] DATA_BASE = 21'h0_0002;
    localparam logic [7:0] DATA_DONE = 8'hFF;
    localparam logic [7:0] DATA_ZERO = 8'h00;

    // ****************************************
    // Output width codes
    // ****************************************
    localparam logic [2:0] W1 = 3'h0;
    localparam logic [2:0] W2 = 3'h1;
    localparam logic [2:0] W4 = 3'h2;
    localparam logic [2:0] W8 = 3'h3;
    localparam logic [2:0] WPAR = 3'h4;

    typedef enum logic [3:0] {
        S_POR = 4'h0,
        S_OPT = 4'h1,
        S_WAIT = 4'h2,
        S_CFG = 4'h3,
        S_CHK = 4'h4,
        S_IDLE = 4'h5,
        S_PROG = 4'h6,
        S_PULSE = 4'h7,
        S_HOLD = 4'h8
    } cfs_state_e;

    typedef enum logic [1:0] {
        L_OFF = 2'h0,
        L_RUN = 2'h1,
        L_CHK = 2'h2,
        L_DONE = 2'h3
    } cfs_lstate_e;

    typedef struct packed {
        logic drive_n;
        logic ce_n;
        logic oe_n;
        logic we_n;
        logic [FA_W-1:0] addr;
        logic [15:0] wdata;
    } cfs_flash_s;

    typedef struct packed {
        logic valid;
        logic [FA_W-1:0] addr;
        logic [15:0] wdata;
    } cfs_prog_s;

    // ****************************************
    // Width decoding
    // ****************************************
    function automatic logic [3:0] cfs_step(input logic [2:0] wc);
        case (wc)
            W1: cfs_step = 4'h1;
            W2: cfs_step = 4'h2;
            W4: cfs_step = 4'h4;
            default: cfs_step = 4'h8;
        endcase
    endfunction

    function automatic logic [7:0] cfs_mask(input logic [2:0] wc);
        case (wc)
            W1: cfs_mask = 8'h01;
            W2: cfs_mask = 8'h03;
            W4: cfs_mask = 8'h0F;
            default: cfs_mask = 8'hFF;
        endcase
    endfunction

endpackage

// File: verif/cfs_partner.sv
`timescale 1ns/100ps
module cfs_partner (
    input wire logic i_clk,
    input wire cfs_pkg::cfs_flash_s i_flash,
    input wire logic [2:0] i_width,
    output logic [15:0] o_rdata,
    input wire logic i_status_oe_n,
    input wire logic i_hold_low,
    output logic o_status
);
    // ****************************************
    // Flash store and shared data lines
    // ****************************************
    logic [15:0] word;
    logic [15:0] last = 16'h0000;
    always_comb begin
        case (i_flash.addr)
            21'h0_0000: word = {13'h0000, i_width};
            21'h0_0001: word = 16'h0002;
            21'h0_0002: word = 16'hA5C3;
            21'h0_0003: word = 16'h1E7B;
            default: word = 16'h0000;
        endcase
    end
    // Outside master stays released and ignores the pins
    always_ff @(posedge i_clk) begin
        last <= o_rdata;
    end
    // Released lines show a changing pattern
    assign o_rdata = (!i_flash.drive_n && !i_flash.ce_n && !i_flash.oe_n) ? word : ~last;
    // ****************************************
    // Wired status line with pull-up
    // ****************************************
    assign o_status = i_status_oe_n & ~i_hold_low;
endmodule // cfs_partner

// File: verif/cfs_loader_tb.sv
`timescale 1ns/100ps
module cfs_loader_tb;
    localparam int LIM = 4000;
    logic i_clk = 1'b0;
    logic i_link_clk = 1'b0;
    logic i_rst = 1'b1;
    logic i_conf_done = 1'b0;
    logic hold_low = 1'b0;
    logic [2:0] width = 3'h0;
    cfs_pkg::cfs_prog_s i_prog = '0;
    logic i_status;
    logic o_status_oe_n;
    logic o_config_clock_out;
    logic o_prog_ready;
    logic o_idle;
    logic [7:0] o_data;
    cfs_pkg::cfs_flash_s o_flash;
    logic [15:0] i_flash_rdata;
    logic [31:0] acc = 32'h0000_0000;
    logic [7:0] msk = 8'h01;
    logic [7:0] seen = 8'h00;
    int bad_count = 0;
    int tests_run = 0;
    int rises = 0;
    int n = 1;
    int k;
    always #2 i_clk = ~i_clk;
    initial begin
        #1.3;
        forever #6 i_link_clk = ~i_link_clk;
    end
    cfs_loader #(.POR_CYCLES(2), .PULSE_CYCLES(2)) u_cfs_loader (.i_clk(i_clk), .i_rst(i_rst),
        .i_link_clk(i_link_clk), .i_status(i_status), .o_status_oe_n(o_status_oe_n),
        .i_conf_done(i_conf_done), .o_config_clock_out(o_config_clock_out), .o_data(o_data),
        .o_flash(o_flash), .i_flash_rdata(i_flash_rdata), .i_prog(i_prog),
        .o_prog_ready(o_prog_ready), .o_idle(o_idle));
    cfs_partner u_cfs_partner (.i_clk(i_clk), .i_flash(o_flash), .i_width(width),
        .o_rdata(i_flash_rdata), .i_status_oe_n(o_status_oe_n), .i_hold_low(hold_low),
        .o_status(i_status));
    // ****************************************
    // Checking and closing
    // ****************************************
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            bad_count++;
            $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic summarize();
        $display("Comparisons %0d, mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    task automatic bounded(input int cnt);
        if (cnt >= LIM) begin
            bad_count++;
            $display("MISMATCH at %0t: wait ran out", $time);
            summarize();
        end
    endtask
    // ****************************************
    // Link monitor
    // ****************************************
    always @(posedge o_config_clock_out) begin
        seen = o_data;
        if (rises < 32 / n) begin
            acc = acc | (32'(o_data & msk) << (rises * n));
            check(32'(o_data & ~msk), 32'h0000_0000);
        end
        rises = rises + 1;
    end
    // Data seen while the clock stands high, before the edge that may move it
    always @(posedge i_link_clk) begin
        if (o_config_clock_out === 1'b1) begin
            check(32'(o_data), 32'(seen));
        end
    end
    // ****************************************
    // Scenarios
    // ****************************************
    task automatic do_reset(input logic [2:0] w, input int nn, input int cyc);
        width <= w;
        i_rst <= 1'b1;
        i_conf_done <= 1'b0;
        repeat (cyc) @(posedge i_clk);
        i_rst <= 1'b0;
        n = nn;
        msk = 8'((9'h001 << nn) - 9'h001);
        rises = 0;
        acc = 32'h0000_0000;
    endtask
    task automatic run_cfg(input logic [2:0] w, input int nn);
        do_reset(w, nn, 12);
        for (k = 0; k < LIM && rises < 32 / n; k++) @(posedge i_clk);
        bounded(k);
        i_conf_done <= 1'b1;
        for (k = 0; k < LIM && o_idle !== 1'b1; k++) @(posedge i_clk);
        bounded(k);
        repeat (20) @(posedge i_clk);
        check(acc, 32'h1E7B_A5C3);
        check(32'(o_config_clock_out), 32'h0000_0000);
        check(32'(o_data), 32'h0000_00FF);
        check(32'(o_flash.drive_n), 32'h0000_0001);
        check(32'({o_idle, o_prog_ready, o_status_oe_n}), 32'h0000_0007);
    endtask
    task automatic prog_write();
        i_prog <= '{valid: 1'b1, addr: 21'h0_0123, wdata: 16'h5A3C};
        for (k = 0; k < LIM && o_prog_ready !== 1'b1; k++) @(posedge i_clk);
        bounded(k);
        @(posedge i_clk);
        i_prog <= '0;
        for (k = 0; k < LIM && o_flash.we_n !== 1'b0; k++) @(posedge i_clk);
        bounded(k);
        #1;
        check(32'({o_flash.drive_n, o_flash.ce_n}), 32'h0000_0000);
        check(32'(o_flash.addr), 32'h0000_0123);
        check(32'(o_flash.wdata), 32'h0000_5A3C);
        check(32'(o_prog_ready), 32'h0000_0000);
        for (k = 0; k < LIM && o_prog_ready !== 1'b1; k++) @(posedge i_clk);
        bounded(k);
        #1;
        check(32'({o_flash.drive_n, o_flash.we_n}), 32'h0000_0003);
    endtask
    task automatic done_timeout();
        do_reset(cfs_pkg::W4, 4, 12);
        // Status is still pulled low from reset until the options are read
        for (k = 0; k < LIM && o_status_oe_n !== 1'b1; k++) @(posedge i_clk);
        bounded(k);
        for (k = 0; k < LIM && o_status_oe_n !== 1'b0; k++) @(posedge i_clk);
        bounded(k);
        check(32'(rises >= 8 + 63 && rises <= 8 + 68), 32'h0000_0001);
        for (k = 0; k < LIM && o_status_oe_n !== 1'b1; k++) @(posedge i_clk);
        bounded(k);
        for (k = 0; k < LIM && o_flash.oe_n !== 1'b0; k++) @(posedge i_clk);
        bounded(k);
        check(32'(o_flash.addr), 32'h0000_0000);
    endtask
    task automatic mid_hold();
        int r;
        do_reset(cfs_pkg::W1, 1, 12);
        for (k = 0; k < LIM && rises < 4; k++) @(posedge i_clk);
        bounded(k);
        hold_low <= 1'b1;
        repeat (30) @(posedge i_clk);
        r = rises;
        repeat (40) @(posedge i_clk);
        check(32'(o_flash.drive_n), 32'h0000_0001);
        check(32'(rises), 32'(r));
        hold_low <= 1'b0;
        for (k = 0; k < LIM && o_flash.oe_n !== 1'b0; k++) @(posedge i_clk);
        bounded(k);
    endtask
    initial begin
        do_reset(cfs_pkg::W1, 1, 8);
        run_cfg(cfs_pkg::W1, 1);
        run_cfg(cfs_pkg::W2, 2);
        run_cfg(cfs_pkg::W4, 4);
        run_cfg(cfs_pkg::W8, 8);
        run_cfg(cfs_pkg::WPAR, 8);
        prog_write();
        done_timeout();
        mid_hold();
        summarize();
    end
endmodule // cfs_loader_tb
